/* design/ppmi_pkg.sv */
// Purpose: shared constants for the pattern-match interrupt unit
// Assumes: one cpu clock domain, 8-bit port
// Notes: timing counts are in cpu clock cycles
package ppmi_pkg;
  localparam int PORT_W = 8;
  // match must persist longer than this many cpu clocks
  localparam int MATCH_HOLD_CPU_CLOCK = 6;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_RST = 3'h0;
  localparam logic [CNT_W-1:0] CNT_FIRE = 3'h6;
  localparam logic [PORT_W-1:0] PORT_SYNC_RST = 8'hff;
  localparam logic FLAG_RST = 1'b0;
endpackage : ppmi_pkg

/* design/ppmi_sync.sv */
// Purpose: two-flop synchroniser for the input port
// Assumes: port pins are asynchronous to the cpu clock
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module ppmi_sync
  import ppmi_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [PORT_W-1:0] d_in,
  output logic [PORT_W-1:0] q_out
);
  logic [PORT_W-1:0] s1_q;
  logic [PORT_W-1:0] s2_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= PORT_SYNC_RST;
      s2_q <= PORT_SYNC_RST;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
    end
  end
  assign q_out = s2_q;
endmodule : ppmi_sync
`default_nettype wire

/* design/ppmi_top.sv */
// Purpose: keypad pattern-match interrupt unit
// Assumes: control bits are plain ports from cpu-clocked logic
// Notes: flag is sticky, cleared by a one-cycle clear pulse
// Operation
// - mask selects pins taking part in match
// - compare port against programmed match pattern
// - sense bit picks equal or not-equal
// - condition while active sets the flag
// - interrupt request from flag when enabled
// - condition must last over six cpu clocks
// - enabled request wakes from idle, power-down
`timescale 1ns/1ps
`default_nettype none
module ppmi_top
  import ppmi_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic NRST_IN,
  input wire logic [PORT_W-1:0] PORT_PINS_IN,
  input wire logic [PORT_W-1:0] PIN_TRIGGER_MASK_IN,
  input wire logic [PORT_W-1:0] MATCH_PATTERN_IN,
  input wire logic COMPARE_SENSE_SELECT_IN,
  input wire logic FUNCTION_ACTIVE_IN,
  input wire logic IRQ_ENABLE_IN,
  input wire logic FLAG_CLEAR_IN,
  output logic PATTERN_MATCH_FLAG_OUT,
  output logic PATTERN_MATCH_IRQ_OUT,
  output logic WAKEUP_OUT
);
  logic [PORT_W-1:0] port_s;
  logic [CNT_W-1:0] hold_cnt_q;
  logic [CNT_W-1:0] hold_cnt_d;
  logic flag_q;
  logic flag_d;
  wire logic [PORT_W-1:0] masked_port;
  wire logic [PORT_W-1:0] masked_patn;
  wire logic is_equal;
  wire logic cond;
  wire logic held;
  wire logic [PORT_W-1:0] pin_diff;

  ppmi_sync u_sync (
    .clk_in(CORE_CLK_IN),
    .nrst_in(NRST_IN),
    .d_in(PORT_PINS_IN),
    .q_out(port_s)
  );

  // only enabled pins take part
  assign masked_port = port_s & PIN_TRIGGER_MASK_IN;
  assign masked_patn = MATCH_PATTERN_IN & PIN_TRIGGER_MASK_IN;
  // per-pin mismatch, masked pins never differ
  for (genvar gi = 0; gi < PORT_W; gi++) begin : g_pin
    assign pin_diff[gi] = PIN_TRIGGER_MASK_IN[gi] & (port_s[gi] ^ MATCH_PATTERN_IN[gi]);
    AST_PIN_MASKED: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      !PIN_TRIGGER_MASK_IN[gi] |-> !pin_diff[gi])
      else $error("masked pin shows a difference");
  end
  assign is_equal = ~|pin_diff;
  // sense high selects not-equal, the legacy keypad setting
  assign cond = FUNCTION_ACTIVE_IN && (COMPARE_SENSE_SELECT_IN ? !is_equal : is_equal);

  // counter saturates at six; a seventh matching cycle fires
  assign held = cond && (hold_cnt_q == CNT_FIRE);
  assign hold_cnt_d = !cond ? CNT_RST :
                      (hold_cnt_q == CNT_FIRE) ? hold_cnt_q : hold_cnt_q + 3'h1;

  // set wins over clear
  assign flag_d = held ? 1'b1 : (FLAG_CLEAR_IN ? 1'b0 : flag_q);

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      hold_cnt_q <= CNT_RST;
      flag_q <= FLAG_RST;
    end else begin
      hold_cnt_q <= hold_cnt_d;
      flag_q <= flag_d;
    end
  end

  assign PATTERN_MATCH_FLAG_OUT = flag_q;
  assign PATTERN_MATCH_IRQ_OUT = flag_q && IRQ_ENABLE_IN;
  assign WAKEUP_OUT = flag_q && IRQ_ENABLE_IN;

  // helper: cycles the condition has stood, saturating at 15 so it never wraps
  logic [3:0] run_q;
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      run_q <= 4'h0;
    end else if (!cond) begin
      run_q <= 4'h0;
    end else if (run_q != 4'hf) begin
      run_q <= run_q + 4'h1;
    end
  end

  AST_SET_AFTER_HOLD: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (cond && run_q == 4'h6) |=> PATTERN_MATCH_FLAG_OUT)
    else $error("flag not set after seven matching cycles");
  AST_NO_EARLY_SET: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (!PATTERN_MATCH_FLAG_OUT && !(cond && run_q >= 4'h6)) |=> !PATTERN_MATCH_FLAG_OUT)
    else $error("flag set without a long enough match");
  AST_STICKY: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (PATTERN_MATCH_FLAG_OUT && !FLAG_CLEAR_IN) |=> PATTERN_MATCH_FLAG_OUT)
    else $error("flag dropped without clear");
  AST_CLEAR: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (FLAG_CLEAR_IN && !held) |=> !PATTERN_MATCH_FLAG_OUT)
    else $error("clear did not clear flag");
  AST_SET_WINS: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (FLAG_CLEAR_IN && held) |=> PATTERN_MATCH_FLAG_OUT)
    else $error("set lost against clear");
  AST_IRQ_GATE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    PATTERN_MATCH_IRQ_OUT == (PATTERN_MATCH_FLAG_OUT && IRQ_ENABLE_IN))
    else $error("irq not gated by enable");
  AST_WAKE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    WAKEUP_OUT |-> PATTERN_MATCH_IRQ_OUT)
    else $error("wake without irq");
  AST_INACTIVE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (!FUNCTION_ACTIVE_IN && !PATTERN_MATCH_FLAG_OUT) |=> !PATTERN_MATCH_FLAG_OUT)
    else $error("flag set while inactive");
  AST_MASK: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (PIN_TRIGGER_MASK_IN == 8'h00) |-> (is_equal == 1'b1))
    else $error("masked pins affect compare");
  AST_SENSE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (FUNCTION_ACTIVE_IN && COMPARE_SENSE_SELECT_IN && is_equal) |-> !cond)
    else $error("not-equal sense fires on equal");

  // compare path
  AST_EQ_CROSS: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    is_equal == (masked_port == masked_patn))
    else $error("per-pin compare disagrees with masked compare");

  AST_EQ_SENSE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (FUNCTION_ACTIVE_IN && !COMPARE_SENSE_SELECT_IN) |-> (cond == is_equal))
    else $error("equal sense does not follow compare");

  AST_NEQ_SENSE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (FUNCTION_ACTIVE_IN && COMPARE_SENSE_SELECT_IN) |-> (cond == !is_equal))
    else $error("not-equal sense does not follow compare");

  AST_INACTIVE_COND: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    !FUNCTION_ACTIVE_IN |-> !cond)
    else $error("condition seen while inactive");

  AST_LEGACY: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (FUNCTION_ACTIVE_IN && COMPARE_SENSE_SELECT_IN && (MATCH_PATTERN_IN == 8'hff) &&
     |(~port_s & PIN_TRIGGER_MASK_IN)) |-> cond)
    else $error("enabled low pin missed in keypad setting");

  // hold counter
  AST_CNT_CLEAR: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    !cond |=> (hold_cnt_q == CNT_RST))
    else $error("hold count kept after condition dropped");

  AST_CNT_MAX: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    hold_cnt_q <= CNT_FIRE)
    else $error("hold count beyond its ceiling");

  AST_CNT_STEP: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (cond && (hold_cnt_q != CNT_FIRE)) |=> (hold_cnt_q == $past(hold_cnt_q) + 3'h1))
    else $error("hold count did not step");

  AST_RUN_TRACK: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (run_q <= 4'h6) |-> (hold_cnt_q == run_q[2:0]))
    else $error("hold count lost track of match length");

  AST_RUN_SAT: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (run_q >= 4'h6) |-> (hold_cnt_q == CNT_FIRE))
    else $error("hold count short on a long match");

  AST_HELD_NEEDS_COND: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    held |-> cond)
    else $error("fire without condition");

  AST_SHORT_IGNORED: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (!PATTERN_MATCH_FLAG_OUT && cond && (run_q == 4'h5) ##1 !cond) |=> !PATTERN_MATCH_FLAG_OUT)
    else $error("six-cycle match set the flag");

  // flag and request
  AST_FLAG_CAUSE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    $rose(PATTERN_MATCH_FLAG_OUT) |-> $past(held))
    else $error("flag rose without a held match");

  AST_IRQ_SET: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    held |=> (PATTERN_MATCH_IRQ_OUT == IRQ_ENABLE_IN))
    else $error("request does not follow enable after set");

  AST_IRQ_OFF: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    !IRQ_ENABLE_IN |-> (!PATTERN_MATCH_IRQ_OUT && !WAKEUP_OUT))
    else $error("request while disabled");

  AST_CLEAR_NO_IRQ: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (FLAG_CLEAR_IN && !held) |=> !PATTERN_MATCH_IRQ_OUT)
    else $error("request stands after clear");

  AST_WAKE_ON: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (PATTERN_MATCH_FLAG_OUT && IRQ_ENABLE_IN) |-> WAKEUP_OUT)
    else $error("no wake for an enabled request");

  COV_SET: cover property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    !PATTERN_MATCH_FLAG_OUT ##1 PATTERN_MATCH_FLAG_OUT);
  COV_SHORT: cover property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (cond && run_q == 4'h5) ##1 !cond);
  COV_IRQ: cover property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    PATTERN_MATCH_IRQ_OUT);
  COV_RACE: cover property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    FLAG_CLEAR_IN && held);
  COV_LEGACY: cover property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    (COMPARE_SENSE_SELECT_IN && (MATCH_PATTERN_IN == 8'hff) && held));
endmodule : ppmi_top
`default_nettype wire

/* dv/ppmi_keypad.sv */
// Purpose: keypad switch model on the input port
// Assumes: each pin has a pull-up, a pressed key pulls it low
// Notes: released keys read high, never the last value
`timescale 1ns/1ps
`default_nettype none
module ppmi_keypad
  import ppmi_pkg::*;
(
  input wire logic [PORT_W-1:0] key_press_in,
  output logic [PORT_W-1:0] pins_out
);
  assign pins_out = ~key_press_in;
endmodule : ppmi_keypad
`default_nettype wire

/* dv/testbench.sv */
// Purpose: self-checking bench for the pattern-match unit
// Assumes: keypad model drives the port
// Notes: random cases from a fixed seed among corner cases
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ppmi_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, sense = 1'b0, act = 1'b0, ien = 1'b0, clr = 1'b0;
  logic [PORT_W-1:0] keys = 8'h00, mask = 8'h00, pat = 8'h00;
  wire logic [PORT_W-1:0] pins;
  wire logic flag, irq, wake;
  int failures = 0, compares = 0, cycles = 0;
  ppmi_keypad u_ppmi_keypad (.key_press_in(keys), .pins_out(pins));
  ppmi_top u_ppmi_top (.CORE_CLK_IN(clk), .NRST_IN(nrst), .PORT_PINS_IN(pins),
    .PIN_TRIGGER_MASK_IN(mask), .MATCH_PATTERN_IN(pat), .COMPARE_SENSE_SELECT_IN(sense),
    .FUNCTION_ACTIVE_IN(act), .IRQ_ENABLE_IN(ien), .FLAG_CLEAR_IN(clr),
    .PATTERN_MATCH_FLAG_OUT(flag), .PATTERN_MATCH_IRQ_OUT(irq), .WAKEUP_OUT(wake));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic chk(input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic hit(input logic [7:0] p, m, q, input logic s);
    return s ? ((p & m) != (q & m)) : ((p & m) == (q & m));
  endfunction : hit
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // settle the port, hold the function active for hold cycles, then drop it
  task automatic run(input logic [7:0] k, m, q, input logic s, e, input int hold);
    logic exp;
    keys = k; mask = m; pat = q; sense = s; ien = e;
    step(3);
    act = 1'b1;
    step(hold);
    act = 1'b0;
    step(1);
    exp = hit(~k, m, q, s) && (hold > MATCH_HOLD_CPU_CLOCK);
    chk(flag, exp);
    chk(irq, exp & e);
    chk(wake, exp & e);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    chk(flag, 1'b0);
  endtask : run
  initial begin
    void'($urandom(32'hfb90));
    step(6);
    nrst = 1'b1;
    step(1);
    chk(flag, FLAG_RST);
    run(8'h04, 8'hff, 8'hff, 1'b1, 1'b1, 7);
    run(8'h04, 8'hff, 8'hff, 1'b1, 1'b1, 6);
    run(8'h04, 8'hfb, 8'hff, 1'b1, 1'b1, 9);
    run(8'h00, 8'h00, 8'h5a, 1'b0, 1'b0, 7);
    run(8'ha5, 8'hf0, 8'h5f, 1'b0, 1'b1, 8);
    for (int i = 0; i < 40; i++) begin
      run(8'($urandom), 8'($urandom), 8'($urandom), 1'($urandom), 1'($urandom),
        int'(5 + $urandom % 5));
    end
    keys = 8'h01; mask = 8'hff; pat = 8'hff; sense = 1'b1;
    step(3);
    act = 1'b1;
    step(9);
    nrst = 1'b0;
    step(1);
    chk(flag, 1'b0);
    act = 1'b0;
    nrst = 1'b1;
    step(2);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
